// file: rtl/led_scan_pkg.sv
package led_scan_pkg;

   // Clock and scan oscillator
   localparam int unsigned CLK_MHZ        = 100;
   localparam int unsigned TICK_US        = 1;
   localparam int unsigned TICK_CYCLES    = CLK_MHZ * TICK_US;
   localparam int unsigned DIGIT_ON_US    = 320;
   localparam int unsigned GAP_US         = 10;
   localparam int unsigned GAP_MIN_US     = 2;
   localparam int unsigned DIGIT_ON_TICKS = DIGIT_ON_US / TICK_US;
   localparam int unsigned GAP_TICKS      = GAP_US / TICK_US;
   localparam int unsigned GAP_MIN_TICKS  = (GAP_MIN_US + TICK_US - 1) / TICK_US;
   localparam int unsigned TICK_CNT_W     = 10;
   localparam int unsigned DIV_CNT_W      = 16;

   // Display memory
   localparam int unsigned DIGITS   = 8;
   localparam int unsigned ADDR_W   = 3;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned SEG_W    = 7;

   // Control word fields
   localparam int unsigned CTRL_ADDR_LSB    = 0;
   localparam int unsigned CTRL_POWER_ON    = 4;
   localparam int unsigned CTRL_DECODE      = 5;
   localparam int unsigned CTRL_HEX         = 6;
   localparam int unsigned CTRL_DATA_COMING = 7;
   localparam logic [7:0]  CTRL_RESET       = 8'h70;

   // Data byte fields
   localparam int unsigned POINT_BIT = 7;
   localparam int unsigned CODE_W    = 4;
   localparam logic [7:0]  DATA_RESET = 8'hff;
   localparam logic [7:0]  RANDOM_KEEP = 8'h8f;

   // Raw segment mode bit positions
   localparam int unsigned RAW_A = 6;
   localparam int unsigned RAW_B = 5;
   localparam int unsigned RAW_C = 4;
   localparam int unsigned RAW_E = 3;
   localparam int unsigned RAW_G = 2;
   localparam int unsigned RAW_F = 1;
   localparam int unsigned RAW_D = 0;

   // Scan order, position 0 in the low bits: digits 2,5,1,7,8,6,4,3
   localparam logic [23:0] SCAN_ORDER = {3'h2, 3'h3, 3'h5, 3'h7, 3'h6, 3'h0, 3'h4, 3'h1};

   typedef enum logic [1:0] {
      FMT_HEX   = 2'h0,
      FMT_CODEB = 2'h1,
      FMT_RAW   = 2'h2
   } fmt_t;

   typedef enum logic [1:0] {
      ST_STANDBY = 2'h0,
      ST_GAP     = 2'h1,
      ST_SETUP   = 2'h2,
      ST_ON      = 2'h3
   } scan_state_t;

endpackage

// file: rtl/seg_decoder.sv
`timescale 1ns/1ps
module seg_decoder (
   input  wire logic [7:0]         data,
   input  led_scan_pkg::fmt_t      fmt,
   output logic      [6:0]         seg,
   output logic                    point
);
   logic [3:0] code;

   assign code = data[led_scan_pkg::CODE_W-1:0];

   always_comb begin
      seg   = 7'h00;
      point = ~data[led_scan_pkg::POINT_BIT];
      case (fmt)
         led_scan_pkg::FMT_RAW: begin
            seg[0] = data[led_scan_pkg::RAW_A];
            seg[1] = data[led_scan_pkg::RAW_B];
            seg[2] = data[led_scan_pkg::RAW_C];
            seg[3] = data[led_scan_pkg::RAW_D];
            seg[4] = data[led_scan_pkg::RAW_E];
            seg[5] = data[led_scan_pkg::RAW_F];
            seg[6] = data[led_scan_pkg::RAW_G];
         end
         led_scan_pkg::FMT_HEX: begin
            case (code)
               4'h0: seg = 7'h3f;
               4'h1: seg = 7'h06;
               4'h2: seg = 7'h5b;
               4'h3: seg = 7'h4f;
               4'h4: seg = 7'h66;
               4'h5: seg = 7'h6d;
               4'h6: seg = 7'h7d;
               4'h7: seg = 7'h07;
               4'h8: seg = 7'h7f;
               4'h9: seg = 7'h6f;
               4'ha: seg = 7'h77;
               4'hb: seg = 7'h7c;
               4'hc: seg = 7'h39;
               4'hd: seg = 7'h5e;
               4'he: seg = 7'h79;
               default: seg = 7'h71;
            endcase
         end
         default: begin
            case (code)
               4'h0: seg = 7'h3f;
               4'h1: seg = 7'h06;
               4'h2: seg = 7'h5b;
               4'h3: seg = 7'h4f;
               4'h4: seg = 7'h66;
               4'h5: seg = 7'h6d;
               4'h6: seg = 7'h7d;
               4'h7: seg = 7'h07;
               4'h8: seg = 7'h7f;
               4'h9: seg = 7'h6f;
               4'ha: seg = 7'h40;
               4'hb: seg = 7'h79;
               4'hc: seg = 7'h76;
               4'hd: seg = 7'h38;
               4'he: seg = 7'h73;
               default: seg = 7'h00;
            endcase
         end
      endcase
   end
endmodule // seg_decoder

// file: rtl/led_scan_shutdown_blanking.sv
`timescale 1ns/1ps
module led_scan_shutdown_blanking #(
   parameter int unsigned TICK_DIV = led_scan_pkg::TICK_CYCLES
) (
   input  wire logic                                   clk_sys,
   input  wire logic                                   resetn,
   input  wire logic                                   random_access,
   input  wire logic                                   format_pin_high,
   input  wire logic                                   format_pin_low,
   input  wire logic                                   wr_strobe,
   input  wire logic                                   wr_control,
   input  wire logic [led_scan_pkg::ADDR_W-1:0]        wr_addr,
   input  wire logic [led_scan_pkg::DATA_W-1:0]        wr_data,
   output logic      [led_scan_pkg::DIGITS-1:0]        digit_strobe_outputs,
   output logic      [led_scan_pkg::SEG_W-1:0]         segment_outputs,
   output logic                                        point_output,
   output logic                                        standby_active,
   output logic                                        load_active
);
   logic [1:0]                          rst_pipe;
   logic                                rst_n;
   logic [1:0]                          pin_high_pipe;
   logic [1:0]                          pin_low_pipe;
   logic                                pin_high;
   logic                                pin_low;
   logic [led_scan_pkg::DATA_W-1:0]     ctrl;
   logic                                seq_active;
   logic                                seq_locked;
   logic [led_scan_pkg::ADDR_W-1:0]     seq_idx;
   logic [led_scan_pkg::DATA_W-1:0]     mem [led_scan_pkg::DIGITS];
   logic                                standby;
   led_scan_pkg::fmt_t                  fmt;
   logic [led_scan_pkg::DIV_CNT_W-1:0]  div_cnt;
   logic                                tick;
   led_scan_pkg::scan_state_t           state;
   logic [led_scan_pkg::TICK_CNT_W-1:0] tick_cnt;
   logic [led_scan_pkg::ADDR_W-1:0]     pos;
   logic [led_scan_pkg::ADDR_W-1:0]     cur_digit;
   logic                                blank_n;
   logic [led_scan_pkg::SEG_W-1:0]      dec_seg;
   logic                                dec_point;
   logic                                data_wr;
   logic [led_scan_pkg::ADDR_W-1:0]     wr_index;
   logic [led_scan_pkg::DATA_W-1:0]     wr_value;

   localparam logic [led_scan_pkg::TICK_CNT_W-1:0] GAP_LAST =
      led_scan_pkg::TICK_CNT_W'(led_scan_pkg::GAP_TICKS - 1);
   localparam logic [led_scan_pkg::TICK_CNT_W-1:0] ON_LAST =
      led_scan_pkg::TICK_CNT_W'(led_scan_pkg::DIGIT_ON_TICKS - 1);
   localparam logic [led_scan_pkg::DIV_CNT_W-1:0] DIV_LAST =
      led_scan_pkg::DIV_CNT_W'(TICK_DIV - 1);

   // Reset release
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Three-level pin comparators come from outside the clock domain
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_high_pipe <= 2'h0;
         pin_low_pipe  <= 2'h0;
      end else begin
         pin_high_pipe <= {pin_high_pipe[0], format_pin_high};
         pin_low_pipe  <= {pin_low_pipe[0], format_pin_low};
      end
   end
   assign pin_high = pin_high_pipe[1];
   assign pin_low  = pin_low_pipe[1];

   // Control word latch
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= led_scan_pkg::CTRL_RESET;
      end else if (wr_strobe && wr_control && !random_access) begin
         ctrl <= wr_data;
      end
   end

   // Sequential load bookkeeping
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seq_active <= 1'b0;
         seq_locked <= 1'b0;
         seq_idx    <= '0;
      end else if (wr_strobe && wr_control && !random_access) begin
         seq_active <= wr_data[led_scan_pkg::CTRL_DATA_COMING];
         seq_locked <= 1'b0;
         seq_idx    <= '0;
      end else if (wr_strobe && !wr_control && !random_access && seq_active) begin
         seq_idx <= seq_idx + 3'h1;
         if (seq_idx == 3'h7) begin
            seq_active <= 1'b0;
            seq_locked <= 1'b1;
         end
      end
   end

   // Write address and value for each variant
   always_comb begin
      data_wr  = wr_strobe && !wr_control;
      wr_index = wr_addr;
      wr_value = wr_data & led_scan_pkg::RANDOM_KEEP;
      if (!random_access) begin
         data_wr  = wr_strobe && !wr_control && !seq_locked;
         wr_index = seq_active ? seq_idx : ctrl[led_scan_pkg::CTRL_ADDR_LSB +: 3];
         wr_value = wr_data;
      end
   end

   // Display memory, written regardless of standby
   genvar g;
   generate
      for (g = 0; g < led_scan_pkg::DIGITS; g++) begin : g_mem
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               mem[g] <= led_scan_pkg::DATA_RESET;
            end else if (data_wr && wr_index == 3'(g)) begin
               mem[g] <= wr_value;
            end
         end
      end
   endgenerate

   // Standby and format selection
   always_comb begin
      if (random_access) begin
         standby = pin_low;
         fmt     = pin_high ? led_scan_pkg::FMT_HEX : led_scan_pkg::FMT_CODEB;
      end else begin
         standby = !ctrl[led_scan_pkg::CTRL_POWER_ON];
         if (!ctrl[led_scan_pkg::CTRL_DECODE]) begin
            fmt = led_scan_pkg::FMT_RAW;
         end else if (ctrl[led_scan_pkg::CTRL_HEX]) begin
            fmt = led_scan_pkg::FMT_HEX;
         end else begin
            fmt = led_scan_pkg::FMT_CODEB;
         end
      end
   end

   // Scan oscillator, stopped in standby
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= '0;
         tick    <= 1'b0;
      end else if (standby) begin
         div_cnt <= '0;
         tick    <= 1'b0;
      end else if (div_cnt == DIV_LAST) begin
         div_cnt <= '0;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 16'h1;
         tick    <= 1'b0;
      end
   end

   // Scan sequencer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state    <= led_scan_pkg::ST_STANDBY;
         tick_cnt <= '0;
         pos      <= '0;
      end else if (standby) begin
         state    <= led_scan_pkg::ST_STANDBY;
         tick_cnt <= '0;
         pos      <= '0;
      end else begin
         case (state)
            led_scan_pkg::ST_STANDBY: begin
               state    <= led_scan_pkg::ST_GAP;
               tick_cnt <= '0;
            end
            led_scan_pkg::ST_GAP: begin
               if (tick) begin
                  if (tick_cnt == GAP_LAST) begin
                     state    <= led_scan_pkg::ST_SETUP;
                     tick_cnt <= '0;
                  end else begin
                     tick_cnt <= tick_cnt + 10'h1;
                  end
               end
            end
            led_scan_pkg::ST_SETUP: begin
               state <= led_scan_pkg::ST_ON;
            end
            led_scan_pkg::ST_ON: begin
               if (tick) begin
                  if (tick_cnt == ON_LAST) begin
                     state    <= led_scan_pkg::ST_GAP;
                     tick_cnt <= '0;
                     pos      <= pos + 3'h1;
                  end else begin
                     tick_cnt <= tick_cnt + 10'h1;
                  end
               end
            end
            default: begin
               state    <= led_scan_pkg::ST_GAP;
               tick_cnt <= '0;
            end
         endcase
      end
   end

   assign cur_digit = led_scan_pkg::SCAN_ORDER[pos*3 +: 3];
   assign blank_n = !standby && (state == led_scan_pkg::ST_SETUP ||
                                 state == led_scan_pkg::ST_ON);

   seg_decoder u_dec (
      .data  (mem[cur_digit]),
      .fmt   (fmt),
      .seg   (dec_seg),
      .point (dec_point)
   );

   // Output drivers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         segment_outputs <= '0;
         point_output    <= 1'b0;
      end else if (!blank_n || seq_active) begin
         segment_outputs <= '0;
         point_output    <= 1'b0;
      end else begin
         segment_outputs <= dec_seg;
         point_output    <= dec_point;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         digit_strobe_outputs <= '0;
      end else if (blank_n && state == led_scan_pkg::ST_ON) begin
         digit_strobe_outputs <= 8'h01 << cur_digit;
      end else begin
         digit_strobe_outputs <= '0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         standby_active <= 1'b0;
         load_active    <= 1'b0;
      end else begin
         standby_active <= standby;
         load_active    <= seq_active;
      end
   end

   // Checking helpers
   logic [15:0] dark_run;
   logic [15:0] on_run;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dark_run <= '0;
         on_run   <= '0;
      end else begin
         dark_run <= (digit_strobe_outputs == '0) ? dark_run + 16'h1 : '0;
         on_run   <= (digit_strobe_outputs != '0) ? on_run + 16'h1 : '0;
      end
   end

   a_standby_dark: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(standby) && standby |-> digit_strobe_outputs == '0 && segment_outputs == '0
                                   && !point_output && !tick)
      else $error("drivers or oscillator active in standby");

   a_write_standby: assert property (@(posedge clk_sys) disable iff (!rst_n)
      standby && data_wr |=> mem[$past(wr_index)] == $past(wr_value))
      else $error("write lost in standby");

   a_ctrl_standby: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_strobe && wr_control && !random_access && !wr_data[led_scan_pkg::CTRL_POWER_ON]
      ##1 !random_access |-> ##1 state == led_scan_pkg::ST_STANDBY)
      else $error("control word did not enter standby");

   a_pin_standby: assert property (@(posedge clk_sys) disable iff (!rst_n)
      random_access && pin_low |=> state == led_scan_pkg::ST_STANDBY || !random_access)
      else $error("pin low did not enter standby");

   a_gap_min: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(digit_strobe_outputs != '0) && $past(dark_run) != $past(dark_run, 2)
      |-> $past(dark_run) >= 16'(led_scan_pkg::GAP_MIN_TICKS * TICK_DIV))
      else $error("blanking gap too short");

   a_gap_dark: assert property (@(posedge clk_sys) disable iff (!rst_n)
      digit_strobe_outputs == '0 && $past(digit_strobe_outputs) != '0
      |-> segment_outputs == '0 && !point_output)
      else $error("segments lit during gap");

   a_setup_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(digit_strobe_outputs != '0) |-> $stable(segment_outputs) && $stable(point_output))
      else $error("segments changed as digit enabled");

   a_scan_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == led_scan_pkg::ST_ON && $past(state) == led_scan_pkg::ST_SETUP && pos == 3'h0
      |-> cur_digit == 3'h1)
      else $error("scan does not start at digit 2");

   a_on_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(digit_strobe_outputs != '0) && !$past(standby)
      |-> on_run == 16'(led_scan_pkg::DIGIT_ON_TICKS * TICK_DIV - 1))
      else $error("digit on time wrong");

   a_blank_standby: assert property (@(posedge clk_sys) disable iff (!rst_n)
      standby || standby_active |-> !blank_n)
      else $error("blanking released in standby");

   a_restart_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == led_scan_pkg::ST_STANDBY && !standby |=> state == led_scan_pkg::ST_GAP
      && pos == 3'h0 ##1 digit_strobe_outputs == '0)
      else $error("scan did not restart with a gap");

endmodule // led_scan_shutdown_blanking

// file: test/led_panel_model.sv
`timescale 1ns/1ps
// Eight-digit panel: records each digit visit, its timing and what it showed
module led_panel_model (
   input  wire logic        clk_sys,
   input  wire logic [7:0]  digit_strobe_outputs,
   input  wire logic [6:0]  segment_outputs,
   input  wire logic        point_output,
   output int               visits,
   output logic      [2:0]  last_digit,
   output int               on_len,
   output int               gap_len,
   output logic      [63:0] seen,
   output int               errs
);
   logic [7:0] prev_dig;
   logic [7:0] prev_pat;
   logic [7:0] pat;
   int         on_cnt;
   int         gap_cnt;
   logic       dark_lit;

   assign pat = {point_output, segment_outputs};

   initial begin
      visits = 0; last_digit = 3'h0; on_len = 0; gap_len = 0; seen = '0; errs = 0;
      prev_dig = 8'h00; prev_pat = 8'h00; on_cnt = 0; gap_cnt = 0; dark_lit = 1'b0;
   end

   always @(posedge clk_sys) begin
      if (digit_strobe_outputs != 8'h00 && prev_dig == 8'h00) begin
         visits  <= visits + 1;
         gap_len <= gap_cnt;
         on_cnt  <= 1;
         for (int i = 0; i < 8; i++) begin
            if (digit_strobe_outputs[i]) begin
               last_digit     <= 3'(i);
               seen[i*8 +: 8] <= pat;
            end
         end
         if (pat !== prev_pat) errs <= errs + 1;
      end else if (digit_strobe_outputs != 8'h00) begin
         on_cnt <= on_cnt + 1;
      end
      if (digit_strobe_outputs == 8'h00 && prev_dig != 8'h00) on_len <= on_cnt;
      gap_cnt <= (digit_strobe_outputs == 8'h00) ? gap_cnt + 1 : 0;
      if ($countones(digit_strobe_outputs) > 1) errs <= errs + 1;
      if (digit_strobe_outputs != 8'h00) begin
         dark_lit <= 1'b0;
      end else if (pat != 8'h00) begin
         if (dark_lit) errs <= errs + 1;
         dark_lit <= 1'b1;
      end
      prev_dig <= digit_strobe_outputs;
      prev_pat <= pat;
   end
endmodule // led_panel_model

// file: test/led_scan_shutdown_blanking_tb.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) check_val(what, exp, got)
module led_scan_shutdown_blanking_tb;
   localparam int TD = 2;
   logic        clk_sys, resetn, random_access, format_pin_high, format_pin_low;
   logic        wr_strobe, wr_control, standby_active, load_active, point_output;
   logic [2:0]  wr_addr, last_digit;
   logic [7:0]  wr_data, digit_strobe_outputs;
   logic [6:0]  segment_outputs;
   logic [63:0] seen;
   int          visits, on_len, gap_len, errs, n_errors, n_compared;
   logic [2:0]  ord [8] = '{3'h1, 3'h4, 3'h0, 3'h6, 3'h7, 3'h5, 3'h3, 3'h2};

   led_scan_shutdown_blanking #(.TICK_DIV(TD)) uut (.clk_sys(clk_sys), .resetn(resetn),
      .random_access(random_access), .format_pin_high(format_pin_high),
      .format_pin_low(format_pin_low), .wr_strobe(wr_strobe), .wr_control(wr_control),
      .wr_addr(wr_addr), .wr_data(wr_data), .digit_strobe_outputs(digit_strobe_outputs),
      .segment_outputs(segment_outputs), .point_output(point_output),
      .standby_active(standby_active), .load_active(load_active));
   led_panel_model panel (.clk_sys(clk_sys), .digit_strobe_outputs(digit_strobe_outputs),
      .segment_outputs(segment_outputs), .point_output(point_output), .visits(visits),
      .last_digit(last_digit), .on_len(on_len), .gap_len(gap_len), .seen(seen), .errs(errs));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check_val(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic wr(input logic ctl, input logic [7:0] d, input logic [2:0] a);
      @(posedge clk_sys); #1;
      wr_strobe = 1'b1; wr_control = ctl; wr_data = d; wr_addr = a;
      @(posedge clk_sys); #1;
      wr_strobe = 1'b0;
   endtask

   task automatic wait_visits(input int n);
      int t, c;
      t = visits + n;
      c = 0;
      while (visits < t && c < n * 2000) begin
         @(posedge clk_sys); #1;
         c++;
      end
      `CHECK("visit arrived", 1'b1, visits >= t);
   endtask

   task automatic count_dark(input int n, inout int bad);
      repeat (n) begin
         @(posedge clk_sys); #1;
         if (digit_strobe_outputs !== 8'h00 || segment_outputs !== 7'h00 || point_output !== 1'b0
             || standby_active !== 1'b1) bad++;
      end
   endtask

   function automatic logic [7:0] raw_exp(input logic [7:0] d);
      return {~d[7], d[2], d[1], d[3], d[0], d[4], d[5], d[6]};
   endfunction

   task automatic test_scan_timing();
      int k;
      k = 0;
      while (last_digit !== 3'h1 && k < 10) begin wait_visits(1); k++; end
      for (int i = 1; i <= 8; i++) begin
         wait_visits(1);
         `CHECK("scan digit", ord[i % 8], last_digit);
         `CHECK("digit on time", 320 * TD - 1, on_len);
         `CHECK("even slot", 1'b1, on_len + gap_len == (320 + 10) * TD);
         `CHECK("gap length", 1'b1, gap_len >= 10 * TD && gap_len <= 10 * TD + 3);
      end
   endtask

   task automatic test_raw_load();
      wr(1'b1, 8'h90, 3'h0);
      for (int i = 0; i < 8; i++) begin
         wr(1'b0, 8'(i * 37 + 5), 3'h0);
         if (i == 0) `CHECK("load active", 1'b1, load_active);
      end
      wait_visits(9);
      `CHECK("load done", 1'b0, load_active);
      for (int i = 0; i < 8; i++) `CHECK("raw digit", raw_exp(8'(i * 37 + 5)), seen[i*8 +: 8]);
   endtask

   task automatic test_raw_blank();
      wr(1'b1, 8'h90, 3'h0);
      for (int i = 0; i < 8; i++) wr(1'b0, 8'h80, 3'h0);
      wait_visits(9);
      `CHECK("raw blank", 64'h0, seen);
   endtask

   task automatic test_codeb_blank();
      wr(1'b1, 8'hb0, 3'h0);
      for (int i = 0; i < 8; i++) wr(1'b0, 8'hff, 3'h0);
      wait_visits(9);
      `CHECK("alternate blank", 64'h0, seen);
      wr(1'b1, 8'h70, 3'h0);
      wait_visits(9);
      `CHECK("hex F", {8{8'h71}}, seen);
   endtask

   task automatic test_standby_seq();
      int bad, v, c;
      bad = 0;
      wr(1'b1, 8'h62, 3'h0);
      repeat (4) @(posedge clk_sys);
      v = visits;
      count_dark(1000, bad);
      wr(1'b0, 8'h08, 3'h0);
      count_dark(1000, bad);
      `CHECK("standby dark", 0, bad);
      `CHECK("oscillator stopped", v, visits);
      wr(1'b1, 8'h72, 3'h0);
      c = 0;
      while (visits == v && c < 200) begin @(posedge clk_sys); #1; c++; end
      `CHECK("restart digit", 3'h1, last_digit);
      `CHECK("restart gap", 1'b1, c >= 10 * TD && c <= 10 * TD + 6);
      wait_visits(9);
      `CHECK("kept write", {{5{8'h71}}, 8'hff, {2{8'h71}}}, seen);
   endtask

   task automatic test_random();
      int bad;
      bad = 0;
      random_access = 1'b1;
      wr(1'b0, 8'h01, 3'h0);
      wr(1'b0, 8'h0a, 3'h1);
      wr(1'b1, 8'h60, 3'h0);
      wait_visits(9);
      `CHECK("pin hex", 16'hf786, seen[15:0]);
      `CHECK("control ignored", 1'b0, standby_active);
      format_pin_high = 1'b0;
      wait_visits(9);
      `CHECK("pin alternate", 16'hc086, seen[15:0]);
      format_pin_low = 1'b1;
      repeat (8) @(posedge clk_sys);
      count_dark(500, bad);
      `CHECK("pin standby", 0, bad);
      format_pin_low = 1'b0;
      wait_visits(2);
   endtask

   initial begin
      n_errors = 0; n_compared = 0;
      resetn = 1'b0; random_access = 1'b0; format_pin_high = 1'b1; format_pin_low = 1'b0;
      wr_strobe = 1'b0; wr_control = 1'b0; wr_addr = 3'h0; wr_data = 8'h00;
      repeat (2) @(posedge clk_sys);
      #1 resetn = 1'b1;
      test_scan_timing();
      test_raw_load();
      test_raw_blank();
      test_codeb_blank();
      test_standby_seq();
      test_random();
      `CHECK("panel errors", 0, errs);
      finish_test();
   end

   initial begin
      #950000;
      n_errors++;
      finish_test();
   end
endmodule // led_scan_shutdown_blanking_tb
